// file: logic/caf_filter_irq.sv
// Receive acceptance filter and interrupt aggregation for fifteen message centers.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "caf_map.svh"
module caf_filter_irq (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic rx_ok,
  input wire logic rx_ext,
  input wire logic [28:0] rx_id,
  input wire logic [7:0] rx_byte1,
  input wire logic [7:0] rx_byte2,
  input wire logic tx_done,
  input wire logic [3:0] tx_center,
  input wire logic tx_retry,
  input wire logic err_event,
  input wire logic stat_event,
  output logic can_irq,
  output logic load_pulse,
  output logic [3:0] load_center,
  output logic load_slot,
  output logic promote15,
  output logic reload_valid,
  output logic [3:0] reload_center
);
  caf_pkg::caf_state_t st_q;
  caf_pkg::caf_state_t st_d;
  caf_frame_if frm ();
  logic [15:0] hits;
  logic [15:0] txc_vec;
  logic [15:0] flag_vec;
  logic [3:0] tgt;
  logic hit_any;
  logic [3:0] txc_idx;
  logic txc_any;
  logic acc;
  logic tgt_du;
  logic tgt_ovw;
  logic [3:0] ci;
  logic [2:0] ck;
  logic c15_written;
  logic [3:0] dlc_in;
  logic [7:0] rd_val;

  assign frm.id = rx_id;
  assign frm.ext = rx_ext;
  assign frm.byte1 = rx_byte1;
  assign frm.byte2 = rx_byte2;
  assign hits[0] = 1'b0;
  assign ci = reg_addr[6:3];
  assign ck = reg_addr[2:0];

  // One match unit per center; the loop over centers 1 to 15 gives fifteen in all.
  for (genvar i = 1; i <= `CAF_NUM_CENTERS; i++)
  begin : g_center
    caf_center_match #(.IS_C15(i == `CAF_NUM_CENTERS)) u_match (
      .frm(frm),
      .fmt(st_q.fmt[i]),
      .ready(st_q.ctrl[i][`CAF_CTRL_READY]),
      .arb(st_q.arb[i]),
      .std_mask(st_q.std_mask),
      .ext_mask(st_q.ext_mask),
      .own_mask(st_q.c15_mask),
      .media_arb(st_q.media_arb),
      .media_mask(st_q.media_mask),
      .hit(hits[i])
    );
  end

  always_comb
  begin
    txc_vec = 16'h0000;
    flag_vec = 16'h0000;
    for (int i = 1; i <= `CAF_NUM_CENTERS; i++)
    begin
      txc_vec[i] = st_q.ctrl[i][`CAF_CTRL_READY] && st_q.fmt[i][`CAF_FMT_DIR] &&
        st_q.ctrl[i][`CAF_CTRL_TXREQ];
      flag_vec[i] = st_q.ctrl[i][`CAF_CTRL_IRQF];
    end
  end

  // Lowest set bit wins, so center 1 has the highest priority.
  caf_first_set #(.W(16)) u_rx_first (
    .vec(hits),
    .idx(tgt),
    .any(hit_any)
  );

  caf_first_set #(.W(16)) u_tx_first (
    .vec(txc_vec),
    .idx(txc_idx),
    .any(txc_any)
  );

  // A frame with bit errors never reaches the acceptance logic.
  assign acc = rx_valid && rx_ok && hit_any;
  assign tgt_du = st_q.ctrl[tgt][`CAF_CTRL_DU];
  assign tgt_ovw = st_q.arb[tgt][`CAF_ARB3_OVW];
  assign dlc_in = (reg_wdata[7:4] > `CAF_DLC_MAX) ? `CAF_DLC_MAX : reg_wdata[7:4];

  always_comb
  begin
    rd_val = `CAF_RST_BYTE;
    if (reg_addr[7])
    begin
      if (ci != 4'h0)
      begin
        case (ck)
          `CAF_OFS_CTRL: rd_val = st_q.ctrl[ci];
          `CAF_OFS_FMT: rd_val = st_q.fmt[ci];
          3'h2, 3'h3, 3'h4, 3'h5: rd_val = st_q.arb[ci][8*(5-int'(ck)) +: 8];
          default: rd_val = `CAF_RST_BYTE;
        endcase
      end
    end
    else
    begin
      case (reg_addr)
        `CAF_ADDR_CAN_CTRL: rd_val = st_q.can_ctrl;
        `CAF_ADDR_EXT_IRQ_EN: rd_val = st_q.ext_irq_en;
        `CAF_ADDR_GLOBAL_EN: rd_val = st_q.global_en;
        8'h04, 8'h05: rd_val = st_q.std_mask[8*(1-int'(reg_addr[0])) +: 8];
        8'h08, 8'h09, 8'h0a, 8'h0b: rd_val = st_q.ext_mask[8*(3-int'(reg_addr[1:0])) +: 8];
        8'h0c, 8'h0d, 8'h0e, 8'h0f: rd_val = st_q.c15_mask[8*(3-int'(reg_addr[1:0])) +: 8];
        8'h10, 8'h11: rd_val = st_q.media_arb[8*(1-int'(reg_addr[0])) +: 8];
        8'h12, 8'h13: rd_val = st_q.media_mask[8*(1-int'(reg_addr[0])) +: 8];
        default: rd_val = `CAF_RST_BYTE;
      endcase
    end
  end

  always_comb
  begin
    st_d = st_q;
    c15_written = 1'b0;
    st_d.load_pulse = 1'b0;
    st_d.load_slot = 1'b0;
    st_d.promote = 1'b0;
    st_d.reload_valid = 1'b0;
    st_d.rdata = reg_rd ? rd_val : `CAF_RST_BYTE;
    // Software writes come first so that any hardware set below wins over a clear.
    if (reg_wr)
    begin
      if (reg_addr[7])
      begin
        if (ci != 4'h0)
        begin
          case (ck)
            `CAF_OFS_CTRL:
            begin
              st_d.ctrl[ci] = reg_wdata;
              c15_written = (ci == `CAF_LAST_CENTER);
            end
            `CAF_OFS_FMT:
            begin
              st_d.fmt[ci] = {dlc_in, reg_wdata[3:0]};
              if (ci == `CAF_LAST_CENTER)
              begin
                st_d.fmt[ci][`CAF_FMT_DIR] = 1'b0;
              end
            end
            3'h2, 3'h3, 3'h4, 3'h5: st_d.arb[ci][8*(5-int'(ck)) +: 8] = reg_wdata;
            default: st_d.ctrl[ci] = st_q.ctrl[ci];
          endcase
        end
      end
      else
      begin
        case (reg_addr)
          `CAF_ADDR_CAN_CTRL: st_d.can_ctrl = reg_wdata;
          `CAF_ADDR_EXT_IRQ_EN: st_d.ext_irq_en = reg_wdata;
          `CAF_ADDR_GLOBAL_EN: st_d.global_en = reg_wdata;
          8'h04, 8'h05: st_d.std_mask[8*(1-int'(reg_addr[0])) +: 8] = reg_wdata;
          8'h08, 8'h09, 8'h0a, 8'h0b:
            st_d.ext_mask[8*(3-int'(reg_addr[1:0])) +: 8] = reg_wdata;
          8'h0c, 8'h0d, 8'h0e, 8'h0f:
            st_d.c15_mask[8*(3-int'(reg_addr[1:0])) +: 8] = reg_wdata;
          8'h10, 8'h11: st_d.media_arb[8*(1-int'(reg_addr[0])) +: 8] = reg_wdata;
          8'h12, 8'h13: st_d.media_mask[8*(1-int'(reg_addr[0])) +: 8] = reg_wdata;
          default: st_d.can_ctrl = st_q.can_ctrl;
        endcase
      end
    end
    // The buffered frame moves up once software has cleared both flags.
    if (c15_written && st_q.buf15_full && !st_d.ctrl[15][`CAF_CTRL_DU] &&
        !st_d.ctrl[15][`CAF_CTRL_IRQF])
    begin
      st_d.buf15_full = 1'b0;
      st_d.promote = 1'b1;
      st_d.ctrl[15][`CAF_CTRL_DU] = 1'b1;
      if (st_q.ctrl[15][`CAF_CTRL_RXIE])
      begin
        st_d.ctrl[15][`CAF_CTRL_IRQF] = 1'b1;
      end
    end
    // A finished transmission ends the request; center 15 never transmits.
    if (tx_done && tx_center != 4'h0 && tx_center != `CAF_LAST_CENTER)
    begin
      st_d.ctrl[tx_center][`CAF_CTRL_TXREQ] = 1'b0;
      if (st_q.ctrl[tx_center][`CAF_CTRL_TXIE])
      begin
        st_d.ctrl[tx_center][`CAF_CTRL_IRQF] = 1'b1;
      end
    end
    if (acc)
    begin
      st_d.load_center = tgt;
      if (!tgt_du || (tgt != `CAF_LAST_CENTER && tgt_ovw))
      begin
        // Unread data is replaced only with overwrite enabled.
        st_d.load_pulse = 1'b1;
        st_d.ctrl[tgt][`CAF_CTRL_DU] = 1'b1;
        if (tgt_du)
        begin
          st_d.ctrl[tgt][`CAF_CTRL_ROW] = 1'b1;
        end
        if (st_q.ctrl[tgt][`CAF_CTRL_RXIE])
        begin
          st_d.ctrl[tgt][`CAF_CTRL_IRQF] = 1'b1;
        end
      end
      else if (tgt == `CAF_LAST_CENTER && (!st_d.buf15_full || tgt_ovw))
      begin
        // A third frame may only replace the buffered one, never the visible one.
        st_d.load_pulse = 1'b1;
        st_d.load_slot = 1'b1;
        st_d.buf15_full = 1'b1;
      end
    end
    if (err_event)
    begin
      st_d.can_ctrl[`CAF_CC_ERR_FLAG] = 1'b1;
    end
    if (stat_event)
    begin
      st_d.can_ctrl[`CAF_CC_STAT_FLAG] = 1'b1;
    end
    // Lowest-numbered pending transmit center avoids priority inversion.
    if (tx_retry && txc_any)
    begin
      st_d.reload_valid = 1'b1;
      st_d.reload_center = txc_idx;
    end
    st_d.irq = ((|flag_vec) ||
      (st_q.can_ctrl[`CAF_CC_ERR_FLAG] && st_q.can_ctrl[`CAF_CC_ERR_IE]) ||
      (st_q.can_ctrl[`CAF_CC_STAT_FLAG] && st_q.can_ctrl[`CAF_CC_STAT_IE])) &&
      st_q.global_en[`CAF_IE_GLOBAL] && st_q.ext_irq_en[`CAF_EXT_CAN_IE];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign can_irq = st_q.irq;
  assign load_pulse = st_q.load_pulse;
  assign load_center = st_q.load_center;
  assign load_slot = st_q.load_slot;
  assign promote15 = st_q.promote;
  assign reload_valid = st_q.reload_valid;
  assign reload_center = st_q.reload_center;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  rx_flag_set_a: assert property (
    rx_valid && rx_ok && hit_any && !tgt_du && st_q.ctrl[tgt][`CAF_CTRL_RXIE]
    |=> load_pulse && !load_slot && st_q.ctrl[load_center][`CAF_CTRL_IRQF])
    else $error("Receive did not set the center flag.");

  flag_no_hw_clear_a: assert property (
    !reg_wr |=> (($past(flag_vec) & ~flag_vec) == 16'h0000))
    else $error("Center flag cleared without a software write.");

  irq_or_a: assert property (
    (|flag_vec) && st_q.global_en[`CAF_IE_GLOBAL] && st_q.ext_irq_en[`CAF_EXT_CAN_IE]
    |=> can_irq)
    else $error("Pending center flag did not raise the interrupt.");

  irq_gate_a: assert property (
    !st_q.global_en[`CAF_IE_GLOBAL] || !st_q.ext_irq_en[`CAF_EXT_CAN_IE] |=> !can_irq)
    else $error("Interrupt raised while disabled.");

  err_gate_a: assert property (
    flag_vec == 16'h0000 && !st_q.can_ctrl[`CAF_CC_ERR_IE] && !st_q.can_ctrl[`CAF_CC_STAT_IE]
    |=> !can_irq)
    else $error("Ungated error or status raised the interrupt.");

  bad_frame_drop_a: assert property (
    rx_valid && !rx_ok && !reg_wr |=> !load_pulse)
    else $error("Frame with bit errors was loaded.");

  first_hit_a: assert property (
    load_pulse |-> (($past(hits) & (16'h0001 << load_center)) != 16'h0000) &&
    (($past(hits) & ((16'h0001 << load_center) - 16'h0001)) == 16'h0000))
    else $error("Frame not given to the first passing center.");

  c15_rx_only_a: assert property (
    !st_q.fmt[15][`CAF_FMT_DIR])
    else $error("Center 15 set to transmit.");

  overwrite_flag_a: assert property (
    acc && tgt != `CAF_LAST_CENTER && tgt_du && !tgt_ovw |=> !load_pulse)
    else $error("Unread center overwritten with overwrite disabled.");

  reload_cause_a: assert property (
    reload_valid |-> $past(tx_retry) &&
    (($past(txc_vec) & (16'h0001 << reload_center)) != 16'h0000))
    else $error("Reload without a retry or pending center.");

  load_cov_c: cover property (load_pulse && !load_slot);
  overwrite_cov_c: cover property (acc && tgt_du && tgt_ovw);
  buffer_cov_c: cover property (load_pulse && load_slot ##[1:50] promote15);
  reload_cov_c: cover property (reload_valid);
endmodule : caf_filter_irq

// file: logic/caf_map.svh
// Address map, field positions, reset values and compare masks of the acceptance filter.
`ifndef CAF_MAP_SVH
`define CAF_MAP_SVH
`define CAF_NUM_CENTERS 15
`define CAF_LAST_CENTER 4'hf
`define CAF_ADDR_CAN_CTRL 8'h00
`define CAF_ADDR_EXT_IRQ_EN 8'h01
`define CAF_ADDR_GLOBAL_EN 8'h02
`define CAF_ADDR_STD_MASK0 8'h04
`define CAF_ADDR_EXT_MASK0 8'h08
`define CAF_ADDR_C15_MASK0 8'h0c
`define CAF_ADDR_MEDIA_ARB0 8'h10
`define CAF_ADDR_MEDIA_MASK0 8'h12
`define CAF_OFS_CTRL 3'h0
`define CAF_OFS_FMT 3'h1
`define CAF_OFS_ARB0 3'h2
`define CAF_OFS_ARB3 3'h5
`define CAF_CTRL_READY 0
`define CAF_CTRL_TXIE 1
`define CAF_CTRL_RXIE 2
`define CAF_CTRL_IRQF 3
`define CAF_CTRL_DU 4
`define CAF_CTRL_ROW 5
`define CAF_CTRL_TXREQ 6
`define CAF_FMT_MEDIA 0
`define CAF_FMT_MASK 1
`define CAF_FMT_EXT 2
`define CAF_FMT_DIR 3
`define CAF_FMT_DLC_LO 4
`define CAF_DLC_MAX 4'h8
`define CAF_ARB3_OVW 0
`define CAF_CC_ERR_IE 0
`define CAF_CC_STAT_IE 1
`define CAF_CC_ERR_FLAG 2
`define CAF_CC_STAT_FLAG 3
`define CAF_EXT_CAN_IE 6
`define CAF_IE_GLOBAL 7
`define CAF_RST_BYTE 8'h00
`define CAF_STD_CARE 32'hffe0_0000
`define CAF_EXT_CARE 32'hffff_fff8
`endif

// file: logic/caf_pkg.sv
// Types shared by the acceptance filter modules.
package caf_pkg;
  typedef logic [7:0] caf_byte_t;
  typedef struct packed {
    logic [15:1][7:0] ctrl;
    logic [15:1][7:0] fmt;
    logic [15:1][31:0] arb;
    logic [7:0] can_ctrl;
    logic [7:0] ext_irq_en;
    logic [7:0] global_en;
    logic [15:0] std_mask;
    logic [31:0] ext_mask;
    logic [31:0] c15_mask;
    logic [15:0] media_arb;
    logic [15:0] media_mask;
    logic buf15_full;
    logic [7:0] rdata;
    logic irq;
    logic load_pulse;
    logic [3:0] load_center;
    logic load_slot;
    logic promote;
    logic reload_valid;
    logic [3:0] reload_center;
  } caf_state_t;
endpackage : caf_pkg

// file: logic/caf_frame_if.sv
// Incoming frame fields shared by all center match units.
`timescale 1ns/1ps
interface caf_frame_if;
  logic [28:0] id;
  logic ext;
  logic [7:0] byte1;
  logic [7:0] byte2;
  modport src (output id, output ext, output byte1, output byte2);
  modport mon (input id, input ext, input byte1, input byte2);
endinterface : caf_frame_if

// file: logic/caf_first_set.sv
// Lowest-numbered set bit finder.
`timescale 1ns/1ps
module caf_first_set #(
  parameter int W = 16
) (
  input wire logic [W-1:0] vec,
  output logic [3:0] idx,
  output logic any
);
  always_comb
  begin
    idx = 4'h0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (vec[i])
      begin
        idx = 4'(i);
      end
    end
  end
  assign any = |vec;
endmodule : caf_first_set

// file: logic/caf_center_match.sv
// Identifier and media byte acceptance test of one message center.
`timescale 1ns/1ps
`include "caf_map.svh"
module caf_center_match #(
  parameter bit IS_C15 = 1'b0
) (
  caf_frame_if.mon frm,
  input wire logic [7:0] fmt,
  input wire logic ready,
  input wire logic [31:0] arb,
  input wire logic [15:0] std_mask,
  input wire logic [31:0] ext_mask,
  input wire logic [31:0] own_mask,
  input wire logic [15:0] media_arb,
  input wire logic [15:0] media_mask,
  output logic hit
);
  logic ext;
  logic [31:0] gmask;
  logic [31:0] emask;
  logic [31:0] care;
  logic [31:0] fword;
  logic id_ok;
  logic med_ok;
  assign ext = fmt[`CAF_FMT_EXT];
  assign gmask = ext ? ext_mask : {std_mask, 16'h0000};
  // Center 15 narrows the global mask with its own.
  assign emask = !fmt[`CAF_FMT_MASK] ? 32'hffff_ffff : (IS_C15 ? (own_mask & gmask) : gmask);
  assign care = ext ? `CAF_EXT_CARE : `CAF_STD_CARE;
  assign fword = ext ? {frm.id, 3'h0} : {frm.id[10:0], 21'h0};
  assign id_ok = (frm.ext == ext) && (((fword ^ arb) & emask & care) == 32'h0000_0000);
  assign med_ok = !fmt[`CAF_FMT_MEDIA] ||
    ((({frm.byte1, frm.byte2} ^ media_arb) & media_mask) == 16'h0000);
  // Transmit centers never take part in reception.
  assign hit = ready && !fmt[`CAF_FMT_DIR] && id_ok && med_ok;
endmodule : caf_center_match

// file: verif/caf_node_model.sv
// Behavioural model of the remote CAN nodes and the bus events they cause.
`timescale 1ns/1ps
module caf_node_model (
  input wire logic clk,
  output logic rx_valid,
  output logic rx_ok,
  output logic rx_ext,
  output logic [28:0] rx_id,
  output logic [7:0] rx_byte1,
  output logic [7:0] rx_byte2,
  output logic tx_done,
  output logic [3:0] tx_center,
  output logic tx_retry,
  output logic err_event,
  output logic stat_event
);
  initial
  begin
    {rx_valid, rx_ok, rx_ext, rx_id, rx_byte1, rx_byte2} = '0;
    {tx_done, tx_center, tx_retry, err_event, stat_event} = '0;
  end
  // Fields are inverted after the strobe so that a stale frame can never look valid.
  task automatic send_frame(input logic ok, input logic ext, input logic [28:0] id,
    input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_ok <= ok;
    rx_ext <= ext;
    rx_id <= id;
    rx_byte1 <= b1;
    rx_byte2 <= b2;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_ok <= 1'b0;
    rx_ext <= ~ext;
    rx_id <= ~id;
    rx_byte1 <= ~b1;
    rx_byte2 <= ~b2;
  endtask : send_frame
  task automatic bus_event(input int kind, input logic [3:0] ctr);
    @(posedge clk);
    case (kind)
      0: tx_done <= 1'b1;
      1: tx_retry <= 1'b1;
      2: err_event <= 1'b1;
      default: stat_event <= 1'b1;
    endcase
    tx_center <= ctr;
    @(posedge clk);
    {tx_done, tx_retry, err_event, stat_event} <= 4'h0;
    tx_center <= ~ctr;
  endtask : bus_event
endmodule : caf_node_model

// file: verif/caf_filter_irq_tb.sv
// Self-checking bench for the acceptance filter and interrupt aggregation.
`timescale 1ns/1ps
module caf_filter_irq_tb;
  typedef struct packed {
    logic ok;
    logic ext;
    logic [28:0] id;
    logic [7:0] b1;
    logic [7:0] b2;
    logic hit;
    logic [3:0] ctr;
    logic slot;
  } caf_tb_frame_t;
  localparam caf_tb_frame_t FRAMES [17] = '{
    '{1'b1, 1'b0, 29'h123, 8'h00, 8'h00, 1'b1, 4'h2, 1'b0},
    '{1'b0, 1'b0, 29'h123, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b0, 29'h055, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b0, 29'h3ff, 8'h00, 8'h00, 1'b1, 4'h5, 1'b0},
    '{1'b1, 1'b0, 29'h4ff, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b0, 29'h122, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b1, 29'h1abcdef0, 8'h00, 8'h00, 1'b1, 4'h6, 1'b0},
    '{1'b1, 1'b1, 29'h0abcdef0, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b0, 29'h6f0, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b0, 29'h0aa, 8'h5a, 8'h13, 1'b1, 4'h7, 1'b0},
    '{1'b1, 1'b0, 29'h0aa, 8'h5b, 8'h13, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b1, 29'h0234, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b1, 29'h1534, 8'h00, 8'h00, 1'b1, 4'hf, 1'b0},
    '{1'b1, 1'b1, 29'h1fff, 8'h00, 8'h00, 1'b1, 4'hf, 1'b1},
    '{1'b1, 1'b1, 29'h1abc, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0},
    '{1'b1, 1'b0, 29'h123, 8'h00, 8'h00, 1'b1, 4'h2, 1'b0},
    '{1'b1, 1'b0, 29'h3ff, 8'h00, 8'h00, 1'b0, 4'h0, 1'b0}
  };
  logic clk, arst_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic rx_valid, rx_ok, rx_ext, tx_done, tx_retry, err_event, stat_event;
  logic [28:0] rx_id;
  logic [7:0] rx_byte1, rx_byte2;
  logic [3:0] tx_center, load_center, reload_center;
  logic can_irq, load_pulse, load_slot, promote15, reload_valid;
  int miscompares;
  int num_checks;
  caf_filter_irq u_caf_filter_irq (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_ok(rx_ok), .rx_ext(rx_ext), .rx_id(rx_id),
    .rx_byte1(rx_byte1), .rx_byte2(rx_byte2), .tx_done(tx_done), .tx_center(tx_center),
    .tx_retry(tx_retry), .err_event(err_event), .stat_event(stat_event), .can_irq(can_irq),
    .load_pulse(load_pulse), .load_center(load_center), .load_slot(load_slot),
    .promote15(promote15), .reload_valid(reload_valid), .reload_center(reload_center));
  caf_node_model u_caf_node_model (.clk(clk), .rx_valid(rx_valid), .rx_ok(rx_ok),
    .rx_ext(rx_ext), .rx_id(rx_id), .rx_byte1(rx_byte1), .rx_byte2(rx_byte2),
    .tx_done(tx_done), .tx_center(tx_center), .tx_retry(tx_retry),
    .err_event(err_event), .stat_event(stat_event));
  always #50 clk = ~clk;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask : reg_check
  // Multi-byte registers put their most significant byte at the lowest address.
  task automatic wr32(input logic [7:0] a, input logic [31:0] w);
    for (int k = 0; k < 4; k++)
      reg_write(a + 8'(k), w[31 - 8 * k -: 8]);
  endtask : wr32
  task automatic cfg(input int x, input logic [7:0] ctl, input logic [7:0] fmt,
    input logic [31:0] w);
    logic [7:0] b;
    b = 8'h80 + 8'(8 * x);
    reg_write(b + 8'h01, fmt);
    wr32(b + 8'h02, w);
    reg_write(b, ctl);
  endtask : cfg
  function automatic logic [31:0] sw(input logic [10:0] id);
    return {id, 21'h0};
  endfunction : sw
  // Sel 0 watches loads, 1 transmit reloads, 2 center 15 promotions.
  task automatic wait_pulse(input int sel, input logic exp, input logic [3:0] ctr,
    input logic slot);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 4 && !seen; i++)
    begin
      #1;
      case (sel)
        0: seen = (load_pulse === 1'b1);
        1: seen = (reload_valid === 1'b1);
        default: seen = (promote15 === 1'b1);
      endcase
      if (seen && sel == 0)
      begin
        chk("load_center", ctr, load_center);
        chk("load_slot", slot, load_slot);
      end
      if (seen && sel == 1)
        chk("reload_center", ctr, reload_center);
      if (!seen)
        @(posedge clk);
    end
    chk($sformatf("pulse %0d", sel), exp, seen);
  endtask : wait_pulse
  task automatic irq_check(input logic exp);
    repeat (3) @(posedge clk);
    #1;
    chk("can_irq", exp, can_irq);
  endtask : irq_check
  initial
  begin
    #2000000;
    miscompares++;
    conclude();
  end
  initial
  begin
    {clk, arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    reg_check(8'h00, 8'h00);
    reg_write(8'h40, 8'hff);
    reg_check(8'h40, 8'h00);
    reg_write(8'h80, 8'hff);
    reg_check(8'h80, 8'h00);
    cfg(1, 8'h00, 8'h00, sw(11'h123));
    cfg(2, 8'h05, 8'h00, sw(11'h123) | 32'h1);
    cfg(3, 8'h01, 8'h00, sw(11'h123));
    cfg(4, 8'h43, 8'h08, sw(11'h055));
    cfg(5, 8'h01, 8'h02, sw(11'h300));
    cfg(6, 8'h01, 8'h04, {29'h1abcdef0, 3'h0});
    cfg(7, 8'h01, 8'h01, sw(11'h0aa));
    cfg(9, 8'h41, 8'h08, sw(11'h111));
    cfg(15, 8'h01, 8'h06, {29'h1234, 3'h0});
    reg_write(8'h04, 8'he0);
    wr32(8'h08, {29'h1ffff0ff, 3'h0});
    wr32(8'h0c, {29'h1fffff00, 3'h0});
    wr32(8'h10, 32'h5ac3ff0f);
    reg_write(8'hc1, 8'hf4);
    reg_check(8'hc1, 8'h84);
    reg_write(8'hf9, 8'h0e);
    reg_check(8'hf9, 8'h06);
    for (int i = 0; i < 17; i++)
    begin
      u_caf_node_model.send_frame(FRAMES[i].ok, FRAMES[i].ext, FRAMES[i].id,
        FRAMES[i].b1, FRAMES[i].b2);
      wait_pulse(0, FRAMES[i].hit, FRAMES[i].ctr, FRAMES[i].slot);
    end
    reg_check(8'h90, 8'h3d);
    reg_check(8'h98, 8'h01);
    reg_check(8'hb0, 8'h11);
    reg_check(8'ha8, 8'h11);
    reg_check(8'hf8, 8'h11);
    reg_write(8'hf8, 8'h01);
    wait_pulse(2, 1'b1, 4'h0, 1'b0);
    reg_check(8'hf8, 8'h11);
    irq_check(1'b0);
    reg_write(8'h02, 8'h80);
    irq_check(1'b0);
    reg_write(8'h01, 8'h40);
    irq_check(1'b1);
    repeat (20) @(posedge clk);
    reg_check(8'h90, 8'h3d);
    reg_write(8'h90, 8'h05);
    irq_check(1'b0);
    u_caf_node_model.bus_event(1, 4'h0);
    wait_pulse(1, 1'b1, 4'h4, 1'b0);
    u_caf_node_model.bus_event(0, 4'h4);
    irq_check(1'b1);
    reg_check(8'ha0, 8'h0b);
    reg_write(8'ha0, 8'h03);
    irq_check(1'b0);
    reg_write(8'h00, 8'h02);
    u_caf_node_model.bus_event(2, 4'h0);
    irq_check(1'b0);
    reg_check(8'h00, 8'h06);
    u_caf_node_model.bus_event(3, 4'h0);
    irq_check(1'b1);
    reg_write(8'h00, 8'h00);
    irq_check(1'b0);
    conclude();
  end
endmodule : caf_filter_irq_tb
